// >>> rtl/hdc_consts.svh
`ifndef HDC_CONSTS_SVH
`define HDC_CONSTS_SVH

// Geometry
`define HDC_NPORTS        4
`define HDC_CNT_W         6
`define HDC_ADR_W         12

// Timing, in nanoseconds, and the derived cycle counts
`define HDC_CLK_NS        100
`define HDC_CONN_NS       2500
`define HDC_DISC_MIN_NS   2000
`define HDC_DISC_MAX_NS   2500
`define HDC_CONN_CYC      ((`HDC_CONN_NS + `HDC_CLK_NS - 1) / `HDC_CLK_NS)
`define HDC_DISC_CYC      ((`HDC_DISC_MIN_NS + `HDC_CLK_NS - 1) / `HDC_CLK_NS)
`define HDC_DISC_MAX_CYC  (`HDC_DISC_MAX_NS / `HDC_CLK_NS)

// Register indices; byte address is four times the index
`define HDC_IDX_INT_STS   8'h40
`define HDC_IDX_INT_MASK  8'h41
`define HDC_IDX_CTRL      8'h42
`define HDC_IDX_ADDR_PEND 8'h43
`define HDC_IDX_HUB_ADDR  8'h44
`define HDC_IDX_FUNC_ADDR 8'h45
`define HDC_IDX_CONNECT   8'h48
`define HDC_IDX_SPEED     8'h4a

// Field positions
`define HDC_CTRL_HUB_CFG  0
`define HDC_CTRL_FUNC_EN  1
`define HDC_PEND_TGT      7
`define HDC_PEND_ARMED    8

// Reset values
`define HDC_RST_PORTS     4'h0
`define HDC_RST_CTRL      2'h0
`define HDC_RST_ADDR      7'h00

`endif

// >>> rtl/hdc_pkg.sv
`default_nettype none

package hdc_pkg;

  // Downstream line state as {D+, D-}
  typedef enum logic [1:0] {
    LS_SE0  = 2'h0,
    LS_LOW  = 2'h1,
    LS_FULL = 2'h2,
    LS_SE1  = 2'h3
  } hdc_line_type;

  // Enumeration phase of hub and compound function
  typedef enum logic [1:0] {
    PH_HUB_ENUM  = 2'h0,
    PH_HUB_READY = 2'h1,
    PH_FUNC      = 2'h3
  } hdc_phase_type;

endpackage

`default_nettype wire

// >>> rtl/hdc_port_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdc_consts.svh"

module hdc_port_detect
  import hdc_pkg::*;
#(
  parameter int CNT_W    = `HDC_CNT_W,
  parameter int CONN_CYC = `HDC_CONN_CYC,
  parameter int DISC_CYC = `HDC_DISC_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clr_i,
  input  wire logic dp_i,
  input  wire logic dm_i,
  input  wire logic conn_i,
  output logic      se0_o,
  output logic      low_o,
  output logic      conn_evt_o,
  output logic      disc_evt_o
);

  localparam logic [CNT_W-1:0] CONN_LIM = CNT_W'(CONN_CYC);
  localparam logic [CNT_W-1:0] DISC_LIM = CNT_W'(DISC_CYC - 1);

  hdc_line_type     line_w;
  hdc_line_type     line_r;
  logic             same_w;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  assign line_w = hdc_line_type'({dp_i, dm_i});
  assign same_w = (line_w == line_r);
  // Duration counter restarts on every change and saturates
  assign cnt_nxt = !same_w ? '0 : ((cnt_r == '1) ? cnt_r : cnt_r + 1'b1);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      line_r <= LS_SE0;
      cnt_r  <= '0;
    end else begin
      line_r <= line_w;
      cnt_r  <= cnt_nxt;
    end
  end

  assign se0_o      = (line_w == LS_SE0);
  assign low_o      = (line_r == LS_LOW);
  // Non-SE0 held for more than the connect time
  assign conn_evt_o = !conn_i && (line_r != LS_SE0) && same_w && (cnt_r >= CONN_LIM);
  // SE0 held for the disconnect time
  assign disc_evt_o = conn_i && (line_r == LS_SE0) && same_w && (cnt_r >= DISC_LIM);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || clr_i);

  a_conn_qualify: assert property (
    conn_evt_o |-> (line_w != LS_SE0) && ($past(line_w, 1) == line_w) && (cnt_r > CONN_LIM - 1))
    else $error("connect reported before the line state was qualified");

  a_disc_window: assert property (
    disc_evt_o |-> (line_w == LS_SE0) && (cnt_r >= DISC_LIM))
    else $error("disconnect reported before SE0 lasted long enough");

endmodule

`default_nettype wire

// >>> rtl/hdc_top.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hdc_consts.svh"

// Summary of operation
// - Compound function is presented only after the hub is enumerated.
// - A new address becomes active only when its status stage completes.
// - Hub and compound function each hold their own USB address.
// - Both lines low on a port means nothing is attached.
// - Hub emits an end-of-packet on repeated traffic at EOF1.
// - D+ low, D- high sets the connect bit and raises the hub interrupt.
// - D+ high, D- low sets connect, clears speed bit, raises interrupt.
// - A connection is recorded after non-SE0 lasts over 2.5 us.
// - SE0 lasting 2.0 to 2.5 us clears connect and raises interrupt.
// - Connect register bits 0 to 3 map ports 1 to 4, one is connected.
// - Chip or bus reset clears connect bits; hardware then resynchronises.
// - Connect register bits 7 to 4 always read zero.
// - Speed bits 0 to 3: one is low speed, zero is full speed.
// - Chip or bus reset clears the speed register.
// - Events on a firmware-forced port raise no hub interrupt.
// - Events still interrupt in suspend, even on a disabled port.
module hdc_top
  import hdc_pkg::*;
#(
  parameter int NPORTS   = `HDC_NPORTS,
  parameter int ADR_W    = `HDC_ADR_W,
  parameter int CNT_W    = `HDC_CNT_W,
  parameter int CONN_CYC = `HDC_CONN_CYC,
  parameter int DISC_CYC = `HDC_DISC_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              usb_bus_reset_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NPORTS-1:0] ds_dp_i,
  input  wire logic [NPORTS-1:0] ds_dm_i,
  input  wire logic [NPORTS-1:0] port_forced_i,
  input  wire logic              status_done_i,
  input  wire logic              eof1_i,
  input  wire logic              rpt_active_i,
  output logic                   irq_o,
  output logic      [6:0]        hub_addr_o,
  output logic      [6:0]        func_addr_o,
  output logic                   func_present_o,
  output logic      [NPORTS-1:0] port_connect_o,
  output logic      [NPORTS-1:0] port_low_speed_o,
  output logic                   gen_eop_o
);

  // Pin synchronisers
  logic [NPORTS-1:0] dp_s1_r;
  logic [NPORTS-1:0] dp_s2_r;
  logic [NPORTS-1:0] dm_s1_r;
  logic [NPORTS-1:0] dm_s2_r;

  // Detector results
  logic [NPORTS-1:0] se0_w;
  logic [NPORTS-1:0] low_w;
  logic [NPORTS-1:0] conn_evt_w;
  logic [NPORTS-1:0] disc_evt_w;
  logic [NPORTS-1:0] event_w;

  // Register state
  logic [NPORTS-1:0] conn_r;
  logic [NPORTS-1:0] conn_nxt;
  logic [NPORTS-1:0] speed_r;
  logic [NPORTS-1:0] speed_nxt;
  logic [NPORTS-1:0] int_sts_r;
  logic [NPORTS-1:0] int_sts_nxt;
  logic [NPORTS-1:0] int_mask_r;
  logic [1:0]        ctrl_r;
  logic [6:0]        pend_addr_r;
  logic              pend_tgt_r;
  logic              pend_armed_r;
  logic [6:0]        hub_addr_r;
  logic [6:0]        func_addr_r;
  hdc_phase_type     phase_r;
  hdc_phase_type     phase_nxt;

  // Bus decode
  logic              clear_w;
  logic              req_w;
  logic              wr_w;
  logic [7:0]        idx_w;
  logic              wr_sts_w;
  logic              wr_mask_w;
  logic              wr_ctrl_w;
  logic              wr_pend_w;
  logic              wr_conn_w;
  logic              wr_speed_w;
  logic              commit_w;
  logic [NPORTS-1:0] wr_low_w;
  logic [31:0]       rdata_w;

  assign clear_w    = rst_i | usb_bus_reset_i;
  assign req_w      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_w       = req_w & wb_we_i & wb_sel_i[0];
  assign idx_w      = wb_adr_i[9:2];
  assign wr_sts_w   = wr_w & (idx_w == `HDC_IDX_INT_STS);
  assign wr_mask_w  = wr_w & (idx_w == `HDC_IDX_INT_MASK);
  assign wr_ctrl_w  = wr_w & (idx_w == `HDC_IDX_CTRL);
  assign wr_pend_w  = wr_w & (idx_w == `HDC_IDX_ADDR_PEND);
  assign wr_conn_w  = wr_w & (idx_w == `HDC_IDX_CONNECT);
  assign wr_speed_w = wr_w & (idx_w == `HDC_IDX_SPEED);
  assign wr_low_w   = wb_dat_i[NPORTS-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_s1_r <= '0;
      dp_s2_r <= '0;
      dm_s1_r <= '0;
      dm_s2_r <= '0;
    end else begin
      dp_s1_r <= ds_dp_i;
      dp_s2_r <= dp_s1_r;
      dm_s1_r <= ds_dm_i;
      dm_s2_r <= dm_s1_r;
    end
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    hdc_port_detect #(
      .CNT_W    (CNT_W),
      .CONN_CYC (CONN_CYC),
      .DISC_CYC (DISC_CYC)
    ) u_detect (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clr_i      (usb_bus_reset_i),
      .dp_i       (dp_s2_r[p]),
      .dm_i       (dm_s2_r[p]),
      .conn_i     (conn_r[p]),
      .se0_o      (se0_w[p]),
      .low_o      (low_w[p]),
      .conn_evt_o (conn_evt_w[p]),
      .disc_evt_o (disc_evt_w[p])
    );
  end

  // Hardware updates win over a firmware write in the same cycle
  assign conn_nxt  = clear_w ? `HDC_RST_PORTS :
                     (((wr_conn_w ? wr_low_w : conn_r) | conn_evt_w) & ~disc_evt_w);
  assign speed_nxt = clear_w ? `HDC_RST_PORTS :
                     ((wr_speed_w ? wr_low_w : speed_r) & ~(conn_evt_w & ~low_w));

  // Forced ports stay silent; suspend and port enable do not gate events
  assign event_w     = (conn_evt_w | disc_evt_w) & ~port_forced_i;
  assign int_sts_nxt = (int_sts_r & ~(wr_sts_w ? wr_low_w : '0)) | event_w;

  always_ff @(posedge clk_i) begin
    conn_r  <= conn_nxt;
    speed_r <= speed_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_sts_r  <= '0;
      int_mask_r <= '0;
      irq_o      <= 1'b0;
    end else begin
      int_sts_r  <= int_sts_nxt;
      int_mask_r <= wr_mask_w ? wr_low_w : int_mask_r;
      irq_o      <= |(int_sts_nxt & (wr_mask_w ? wr_low_w : int_mask_r));
    end
  end

  // Enumeration phase: hub first, then the compound function
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_HUB_ENUM: begin
        if (ctrl_r[`HDC_CTRL_HUB_CFG]) begin
          phase_nxt = PH_HUB_READY;
        end
      end
      PH_HUB_READY: begin
        if (!ctrl_r[`HDC_CTRL_HUB_CFG]) begin
          phase_nxt = PH_HUB_ENUM;
        end else if (ctrl_r[`HDC_CTRL_FUNC_EN]) begin
          phase_nxt = PH_FUNC;
        end
      end
      PH_FUNC: begin
        if (!ctrl_r[`HDC_CTRL_HUB_CFG] || !ctrl_r[`HDC_CTRL_FUNC_EN]) begin
          phase_nxt = PH_HUB_READY;
        end
      end
      default: begin
        phase_nxt = PH_HUB_ENUM;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (clear_w) begin
      ctrl_r         <= `HDC_RST_CTRL;
      phase_r        <= PH_HUB_ENUM;
      func_present_o <= 1'b0;
    end else begin
      ctrl_r         <= wr_ctrl_w ? wb_dat_i[1:0] : ctrl_r;
      phase_r        <= phase_nxt;
      func_present_o <= (phase_nxt == PH_FUNC);
    end
  end

  // Pending address waits for the end of the status stage
  assign commit_w = pend_armed_r & status_done_i;

  always_ff @(posedge clk_i) begin
    if (clear_w) begin
      pend_addr_r  <= `HDC_RST_ADDR;
      pend_tgt_r   <= 1'b0;
      pend_armed_r <= 1'b0;
    end else if (wr_pend_w) begin
      pend_addr_r  <= wb_dat_i[6:0];
      pend_tgt_r   <= wb_dat_i[`HDC_PEND_TGT];
      pend_armed_r <= 1'b1;
    end else if (commit_w) begin
      pend_armed_r <= 1'b0;
    end
  end

  // Bus reset returns both functions to the default address
  always_ff @(posedge clk_i) begin
    if (clear_w) begin
      hub_addr_r  <= `HDC_RST_ADDR;
      func_addr_r <= `HDC_RST_ADDR;
    end else if (commit_w) begin
      hub_addr_r  <= pend_tgt_r ? hub_addr_r : pend_addr_r;
      func_addr_r <= pend_tgt_r ? pend_addr_r : func_addr_r;
    end
  end

  // Read selection; reserved and unmapped bits read zero
  always_comb begin
    rdata_w = 32'h0000_0000;
    if (idx_w == `HDC_IDX_INT_STS) begin
      rdata_w[NPORTS-1:0] = int_sts_r;
    end else if (idx_w == `HDC_IDX_INT_MASK) begin
      rdata_w[NPORTS-1:0] = int_mask_r;
    end else if (idx_w == `HDC_IDX_CTRL) begin
      rdata_w[1:0] = ctrl_r;
    end else if (idx_w == `HDC_IDX_ADDR_PEND) begin
      rdata_w[`HDC_PEND_ARMED:0] = {pend_armed_r, pend_tgt_r, pend_addr_r};
    end else if (idx_w == `HDC_IDX_HUB_ADDR) begin
      rdata_w[6:0] = hub_addr_r;
    end else if (idx_w == `HDC_IDX_FUNC_ADDR) begin
      rdata_w[6:0] = func_addr_r;
    end else if (idx_w == `HDC_IDX_CONNECT) begin
      rdata_w[NPORTS-1:0] = conn_r;
    end else if (idx_w == `HDC_IDX_SPEED) begin
      rdata_w[NPORTS-1:0] = speed_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= (req_w & ~wb_we_i) ? rdata_w : 32'h0000_0000;
    end
  end

  // Outputs and EOF1 end-of-packet request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hub_addr_o       <= `HDC_RST_ADDR;
      func_addr_o      <= `HDC_RST_ADDR;
      port_connect_o   <= `HDC_RST_PORTS;
      port_low_speed_o <= `HDC_RST_PORTS;
      gen_eop_o        <= 1'b0;
    end else begin
      hub_addr_o       <= hub_addr_r;
      func_addr_o      <= func_addr_r;
      port_connect_o   <= conn_r;
      port_low_speed_o <= speed_r;
      gen_eop_o        <= eof1_i & rpt_active_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_func_after_hub: assert property (
    $rose(func_present_o) |-> $past(ctrl_r[`HDC_CTRL_HUB_CFG]) && $past(phase_r) == PH_HUB_READY)
    else $error("compound function presented before hub enumeration");

  a_addr_commit: assert property (
    ($changed(hub_addr_r) || $changed(func_addr_r)) && !$past(usb_bus_reset_i)
      |-> $past(status_done_i) && $past(pend_armed_r))
    else $error("device address changed without a completed status stage");

  a_addr_separate: assert property (
    $past(commit_w) && $past(pend_tgt_r) && !$past(usb_bus_reset_i)
      |-> $stable(hub_addr_r) && func_addr_r == $past(pend_addr_r))
    else $error("function address commit disturbed the hub address");

  a_se0_noconn: assert property (
    ((conn_r & ~$past(conn_r) & $past(se0_w)) != '0) |-> $past(wr_conn_w))
    else $error("connect recorded on a port reading SE0");

  a_eop_eof1: assert property (
    eof1_i && rpt_active_i |=> gen_eop_o ##1 (!gen_eop_o || $past(eof1_i)))
    else $error("end-of-packet not generated at EOF1");

  a_fs_speed_clr: assert property (
    !$past(usb_bus_reset_i) |-> (($past(conn_evt_w & ~low_w) & (speed_r | ~conn_r)) == '0))
    else $error("full speed connect left speed bit set or connect bit clear");

  a_disc_irq: assert property (
    ((disc_evt_w & ~port_forced_i & int_mask_r) != '0) && !wr_mask_w |=> irq_o && (conn_r & $past(disc_evt_w)) == '0)
    else $error("disconnect did not clear connect or raise interrupt");

  a_reset_clear: assert property (
    usb_bus_reset_i |=> conn_r == '0 && speed_r == '0 ##1 hub_addr_o == `HDC_RST_ADDR)
    else $error("bus reset did not clear connect and speed");

  a_reserved_zero: assert property (
    wb_ack_o && $past(idx_w == `HDC_IDX_CONNECT && !wb_we_i) |-> wb_dat_o[31:NPORTS] == '0)
    else $error("reserved connect bits read nonzero");

  a_forced_noirq: assert property (
    ((int_sts_r & ~$past(int_sts_r) & $past(port_forced_i)) == '0))
    else $error("forced port raised a hub interrupt");

endmodule

`default_nettype wire

// >>> verif/hdc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module hdc_dev_model (
  input  wire logic [7:0] mode_i,
  output logic      [3:0] dp_o,
  output logic      [3:0] dm_o
);
  // Two mode bits a port: 0 nothing attached, 1 low speed, 2 full speed
  // With no device the pull-downs leave both lines low
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      dp_o[p] = (mode_i[2*p+:2] == 2'h2);
      dm_o[p] = (mode_i[2*p+:2] == 2'h1);
    end
  end
endmodule
`default_nettype wire

// >>> verif/hub_downstream_connect_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hub_downstream_connect_detect_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        usb_bus_reset_i = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_rd;
  logic [3:0]  port_forced = 4'h0;
  logic        status_done = 1'b0;
  logic        eof1 = 1'b0;
  logic        rpt_active = 1'b0;
  logic [7:0]  dev_mode = 8'h00;
  wire  [3:0]  dp;
  wire  [3:0]  dm;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         irq_o;
  wire  [6:0]  hub_addr_o;
  wire  [6:0]  func_addr_o;
  wire         func_present_o;
  wire  [3:0]  port_connect_o;
  wire  [3:0]  port_low_speed_o;
  wire         gen_eop_o;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;

  always #50 clk_i = ~clk_i;

  hdc_dev_model hdc_dev_model_inst (.mode_i(dev_mode), .dp_o(dp), .dm_o(dm));

  hdc_top hdc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .usb_bus_reset_i(usb_bus_reset_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ds_dp_i(dp), .ds_dm_i(dm), .port_forced_i(port_forced),
    .status_done_i(status_done), .eof1_i(eof1), .rpt_active_i(rpt_active),
    .irq_o(irq_o), .hub_addr_o(hub_addr_o), .func_addr_o(func_addr_o),
    .func_present_o(func_present_o), .port_connect_o(port_connect_o),
    .port_low_speed_o(port_low_speed_o), .gen_eop_o(gen_eop_o)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test;
    end
  end

  // Classic single cycle; ack and read data are taken at the same edge
  task wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {2'h0, idx, 2'h0};
    wb_dat <= d;
    wb_sel <= 4'hf;
    // Waits as long as the slave needs; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task rd(input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    check(wb_rd, exp);
  endtask

  task wait_conn(input int p, input logic v);
    n = 0;
    while (port_connect_o[p] !== v && n < 60) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task pulse_done;
    status_done <= 1'b1;
    @(posedge clk_i);
    status_done <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task t_reset;
    rd(8'h48, 32'h0);
    rd(8'h4a, 32'h0);
    rd(8'h7f, 32'h0);
    check(hub_addr_o, 7'h00);
    check(func_addr_o, 7'h00);
    check(func_present_o, 1'b0);
    $display("test reset done");
  endtask

  task t_low;
    wb(1'b1, 8'h41, 32'hf);
    dev_mode[1:0] <= 2'h1;
    repeat (26) @(posedge clk_i);
    check(port_connect_o[0], 1'b0);
    wait_conn(0, 1'b1);
    check(port_connect_o[0], 1'b1);
    check(irq_o, 1'b1);
    rd(8'h40, 32'h1);
    rd(8'h48, 32'h1);
    wb(1'b1, 8'h4a, 32'h5);
    rd(8'h4a, 32'h5);
    $display("test low_connect done");
  endtask

  task t_full;
    dev_mode[5:4] <= 2'h2;
    wait_conn(2, 1'b1);
    check(port_connect_o[2], 1'b1);
    rd(8'h4a, 32'h1);
    check(port_low_speed_o, 4'h1);
    $display("test full_connect done");
  endtask

  task t_forced;
    wb(1'b1, 8'h40, 32'hf);
    port_forced <= 4'h2;
    dev_mode[3:2] <= 2'h1;
    wait_conn(1, 1'b1);
    check(port_connect_o, 4'h7);
    rd(8'h40, 32'h0);
    check(irq_o, 1'b0);
    $display("test forced done");
  endtask

  task t_disc;
    dev_mode[1:0] <= 2'h0;
    repeat (15) @(posedge clk_i);
    check(port_connect_o[0], 1'b1);
    wait_conn(0, 1'b0);
    check(port_connect_o[0], 1'b0);
    check(n <= 13, 1'b1);
    rd(8'h40, 32'h1);
    wb(1'b1, 8'h41, 32'h0);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    wb(1'b1, 8'h41, 32'hf);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    wb(1'b1, 8'h40, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    $display("test disconnect done");
  endtask

  task t_addr;
    wb(1'b1, 8'h43, 32'h05);
    repeat (3) @(posedge clk_i);
    check(hub_addr_o, 7'h00);
    pulse_done;
    check(hub_addr_o, 7'h05);
    wb(1'b1, 8'h43, 32'h89);
    pulse_done;
    check(func_addr_o, 7'h09);
    check(hub_addr_o, 7'h05);
    wb(1'b1, 8'h42, 32'h2);
    repeat (3) @(posedge clk_i);
    check(func_present_o, 1'b0);
    wb(1'b1, 8'h42, 32'h1);
    wb(1'b1, 8'h42, 32'h3);
    repeat (3) @(posedge clk_i);
    check(func_present_o, 1'b1);
    $display("test address done");
  endtask

  task t_eop;
    eof1 <= 1'b1;
    rpt_active <= 1'b1;
    @(posedge clk_i);
    eof1 <= 1'b0;
    @(posedge clk_i);
    check(gen_eop_o, 1'b1);
    @(posedge clk_i);
    check(gen_eop_o, 1'b0);
    rpt_active <= 1'b0;
    eof1 <= 1'b1;
    @(posedge clk_i);
    eof1 <= 1'b0;
    @(posedge clk_i);
    check(gen_eop_o, 1'b0);
    $display("test eop done");
  endtask

  task t_bus_reset;
    usb_bus_reset_i <= 1'b1;
    @(posedge clk_i);
    usb_bus_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(port_connect_o, 4'h0);
    rd(8'h4a, 32'h0);
    check(hub_addr_o, 7'h00);
    wait_conn(2, 1'b1);
    check(port_connect_o[2], 1'b1);
    $display("test bus_reset done");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_low;
    t_full;
    t_forced;
    t_disc;
    t_addr;
    t_eop;
    t_bus_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
